// ==== core/otm_bank.sv ====
// Alarm mask and critical limit register bank for a five-channel monitor.
// Assumes a command-byte register port driven by the management bus engine,
// readings already converted to whole degrees, and hysteresis from outside.
//
// Operation
// R1: The second alarm mask has one bit per channel (4..1 remote four..one, 0 local); set blocks.
// R2: The third alarm mask is an independent five-bit mask with the same order; set blocks.
// R3: Bits 7 to 5 of both mask registers always read as zero.
// R4: The local limit is an unsigned 0..127 degree value in bits 6 to 0.
// R5: Bit 7 of the local limit is read-only and reads as zero.
// R6: The local limit is the threshold for the local error event.
// R7: Each remote limit is a fully writable unsigned 0..255 degree byte.
// R8: Remote one and two first-tier limits feed only the first output's events.
// R9: Remote three and four limits feed the events of all three outputs.
// R10: Remote one and two second-tier limits feed the second and third outputs.
// R11: An error sets at reading >= limit and clears only below limit minus hysteresis.
// R12: One shared 0..32 degree hysteresis lowers every limit for falling temperature.
// R13: Each active-low alarm is asserted while any event its mask passes is true.
// R14: Reset loads every mask and limit default before the first comparison.
module otm_bank (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] reading_local_i,
  input wire logic [7:0] reading_remote1_i,
  input wire logic [7:0] reading_remote2_i,
  input wire logic [7:0] reading_remote3_i,
  input wire logic [7:0] reading_remote4_i,
  input wire logic [5:0] hyst_i,
  output logic [4:0] error_first_o,
  output logic [4:0] error_shared_o,
  output logic alarm_out_second_n_o,
  output logic alarm_out_third_n_o
);

  otm_pkg::otm_bank_state_type state;
  otm_pkg::otm_bank_state_type next_state;
  logic [7:0] rd_val;
  logic [5:0] hyst_eff;
  logic [7:0] cmp_reading [otm_pkg::OTM_NCMP];
  logic [7:0] cmp_limit [otm_pkg::OTM_NCMP];
  logic [otm_pkg::OTM_NCMP-1:0] cmp_err;
  logic [4:0] ev_first;
  logic [4:0] ev_shared;

  // Out-of-range hysteresis is clamped so a bad setting cannot latch alarms
  assign hyst_eff = (hyst_i > otm_pkg::OTM_HYST_MAX) ? otm_pkg::OTM_HYST_MAX : hyst_i; // see R12

  // Readings and limits per comparator slot
  always_comb begin
    cmp_reading[otm_pkg::OTM_CMP_LOCAL] = reading_local_i;
    cmp_reading[otm_pkg::OTM_CMP_R1T1] = reading_remote1_i;
    cmp_reading[otm_pkg::OTM_CMP_R2T1] = reading_remote2_i;
    cmp_reading[otm_pkg::OTM_CMP_R3] = reading_remote3_i;
    cmp_reading[otm_pkg::OTM_CMP_R4] = reading_remote4_i;
    cmp_reading[otm_pkg::OTM_CMP_R1T2] = reading_remote1_i;
    cmp_reading[otm_pkg::OTM_CMP_R2T2] = reading_remote2_i;
    cmp_limit[otm_pkg::OTM_CMP_LOCAL] = {1'b0, state.local_limit}; // see R6
    cmp_limit[otm_pkg::OTM_CMP_R1T1] = state.r1t1;
    cmp_limit[otm_pkg::OTM_CMP_R2T1] = state.r2t1;
    cmp_limit[otm_pkg::OTM_CMP_R3] = state.r3;
    cmp_limit[otm_pkg::OTM_CMP_R4] = state.r4;
    cmp_limit[otm_pkg::OTM_CMP_R1T2] = state.r1t2;
    cmp_limit[otm_pkg::OTM_CMP_R2T2] = state.r2t2;
  end

  // One comparator per limit register
  for (genvar gi = 0; gi < otm_pkg::OTM_NCMP; gi++) begin : g_cmp
    otm_chan_cmp u_cmp (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .reading_i(cmp_reading[gi]),
      .limit_i(cmp_limit[gi]),
      .hyst_i(hyst_eff),
      .err_o(cmp_err[gi])
    );
  end

  // Route comparator results to outputs by tier
  always_comb begin
    ev_first[otm_pkg::OTM_CH_LOCAL] = cmp_err[otm_pkg::OTM_CMP_LOCAL];
    ev_first[otm_pkg::OTM_CH_R1] = cmp_err[otm_pkg::OTM_CMP_R1T1]; // see R8
    ev_first[otm_pkg::OTM_CH_R2] = cmp_err[otm_pkg::OTM_CMP_R2T1]; // see R8
    ev_first[otm_pkg::OTM_CH_R3] = cmp_err[otm_pkg::OTM_CMP_R3]; // see R9
    ev_first[otm_pkg::OTM_CH_R4] = cmp_err[otm_pkg::OTM_CMP_R4]; // see R9
    ev_shared[otm_pkg::OTM_CH_LOCAL] = cmp_err[otm_pkg::OTM_CMP_LOCAL];
    ev_shared[otm_pkg::OTM_CH_R1] = cmp_err[otm_pkg::OTM_CMP_R1T2]; // see R10
    ev_shared[otm_pkg::OTM_CH_R2] = cmp_err[otm_pkg::OTM_CMP_R2T2]; // see R10
    ev_shared[otm_pkg::OTM_CH_R3] = cmp_err[otm_pkg::OTM_CMP_R3]; // see R9
    ev_shared[otm_pkg::OTM_CH_R4] = cmp_err[otm_pkg::OTM_CMP_R4]; // see R9
  end

  // First-output masking lives elsewhere, so raw events leave the block
  assign error_first_o = ev_first;
  assign error_shared_o = ev_shared;

  // Alarms are pure gating of flops; no extra delay on a critical path
  assign alarm_out_second_n_o = ~|(ev_shared & ~state.mask2); // see R1, see R13
  assign alarm_out_third_n_o = ~|(ev_shared & ~state.mask3); // see R2, see R13

  // Read mux; unmapped command bytes read as zero
  always_comb begin
    unique case (reg_addr_i)
      otm_pkg::OTM_ADDR_MASK2: rd_val = otm_pkg::otm_pad_mask(state.mask2); // see R3
      otm_pkg::OTM_ADDR_MASK3: rd_val = otm_pkg::otm_pad_mask(state.mask3); // see R3
      otm_pkg::OTM_ADDR_LOCAL: rd_val = {1'b0, state.local_limit}; // see R5
      otm_pkg::OTM_ADDR_R1T1: rd_val = state.r1t1;
      otm_pkg::OTM_ADDR_R2T1: rd_val = state.r2t1;
      otm_pkg::OTM_ADDR_R3: rd_val = state.r3;
      otm_pkg::OTM_ADDR_R4: rd_val = state.r4;
      otm_pkg::OTM_ADDR_R1T2: rd_val = state.r1t2;
      otm_pkg::OTM_ADDR_R2T2: rd_val = state.r2t2;
      default: rd_val = otm_pkg::OTM_RDATA_IDLE;
    endcase
  end

  // Register writes and read capture; read returns the value before a same-cycle write
  always_comb begin
    next_state = state;
    if (reg_rd_i) begin
      next_state.rdata = rd_val;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        otm_pkg::OTM_ADDR_MASK2: next_state.mask2 = reg_wdata_i[4:0]; // see R1
        otm_pkg::OTM_ADDR_MASK3: next_state.mask3 = reg_wdata_i[4:0]; // see R2
        otm_pkg::OTM_ADDR_LOCAL: next_state.local_limit = reg_wdata_i[6:0]; // see R4
        otm_pkg::OTM_ADDR_R1T1: next_state.r1t1 = reg_wdata_i; // see R7
        otm_pkg::OTM_ADDR_R2T1: next_state.r2t1 = reg_wdata_i; // see R7
        otm_pkg::OTM_ADDR_R3: next_state.r3 = reg_wdata_i; // see R7
        otm_pkg::OTM_ADDR_R4: next_state.r4 = reg_wdata_i; // see R7
        otm_pkg::OTM_ADDR_R1T2: next_state.r1t2 = reg_wdata_i; // see R7
        otm_pkg::OTM_ADDR_R2T2: next_state.r2t2 = reg_wdata_i; // see R7
        default: ;
      endcase
    end
  end

  // Defaults load under reset, before any compare runs
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state.mask2 <= otm_pkg::OTM_RST_MASK2[4:0]; // see R14
      state.mask3 <= otm_pkg::OTM_RST_MASK3[4:0];
      state.local_limit <= otm_pkg::OTM_RST_LOCAL[6:0];
      state.r1t1 <= otm_pkg::OTM_RST_R_T1;
      state.r2t1 <= otm_pkg::OTM_RST_R_T1;
      state.r3 <= otm_pkg::OTM_RST_R_CRIT;
      state.r4 <= otm_pkg::OTM_RST_R_CRIT;
      state.r1t2 <= otm_pkg::OTM_RST_R_T2;
      state.r2t2 <= otm_pkg::OTM_RST_R_T2;
      state.rdata <= otm_pkg::OTM_RDATA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o = state.rdata;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  chk_mask2_write: assert property ( // see R1
    reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_MASK2 |=> state.mask2 == $past(reg_wdata_i[4:0]))
    else $error("second mask write not stored");
  chk_mask3_indep: assert property ( // see R2
    reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_MASK2 |=> $stable(state.mask3))
    else $error("third mask changed by second mask write");
  chk_mask_rsvd_zero: assert property ( // see R3
    reg_rd_i && (reg_addr_i == otm_pkg::OTM_ADDR_MASK2 || reg_addr_i == otm_pkg::OTM_ADDR_MASK3)
    |=> reg_rdata_o[7:5] == 3'h0)
    else $error("mask reserved bits read nonzero");
  chk_local_bit7: assert property ( // see R5
    reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_LOCAL ##1
    reg_rd_i && !reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_LOCAL
    |=> reg_rdata_o == {1'b0, $past(reg_wdata_i[6:0], 2)})
    else $error("local limit readback wrong");
  chk_remote_full: assert property ( // see R7
    reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_R3 ##1
    reg_rd_i && !reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_R3
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("remote limit not fully writable");
  chk_second_blocked: assert property ( // see R1
    state.mask2 == 5'h1F |-> alarm_out_second_n_o)
    else $error("second alarm asserted with all channels blocked");
  chk_third_pass: assert property ( // see R13
    (|(ev_shared & ~state.mask3)) |-> !alarm_out_third_n_o)
    else $error("third alarm not asserted for passed event");
  chk_tier1_isolated: assert property ( // see R8
    $changed(cmp_err[otm_pkg::OTM_CMP_R1T1]) && $stable(ev_shared) && $stable(state.mask2)
    |-> $stable(alarm_out_second_n_o))
    else $error("first-tier event reached second alarm");
  chk_local_threshold: assert property ( // see R6
    reading_local_i >= {1'b0, state.local_limit} |=> error_shared_o[otm_pkg::OTM_CH_LOCAL])
    else $error("local event missing at local limit");

  // Stores and routing per tier; each event checked against its own limit register
  chk_mask3_write: assert property ( // see R2
    reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_MASK3
    |=> state.mask3 == $past(reg_wdata_i[4:0]))
    else $error("third mask write not stored");
  chk_local_write: assert property ( // see R4
    reg_wr_i && reg_addr_i == otm_pkg::OTM_ADDR_LOCAL
    |=> state.local_limit == $past(reg_wdata_i[6:0]))
    else $error("local limit write not stored");
  chk_tier1_first: assert property ( // see R8
    reading_remote1_i >= state.r1t1 |=> error_first_o[otm_pkg::OTM_CH_R1])
    else $error("first-tier remote one event missing");
  chk_tier2_shared: assert property ( // see R10
    reading_remote2_i >= state.r2t2 |=> error_shared_o[otm_pkg::OTM_CH_R2])
    else $error("second-tier remote two event missing");
  chk_remote3_all: assert property ( // see R9
    reading_remote3_i >= state.r3
    |=> error_first_o[otm_pkg::OTM_CH_R3] && error_shared_o[otm_pkg::OTM_CH_R3])
    else $error("remote three event missing on an output");
  chk_remote4_all: assert property ( // see R9
    reading_remote4_i >= state.r4
    |=> error_first_o[otm_pkg::OTM_CH_R4] && error_shared_o[otm_pkg::OTM_CH_R4])
    else $error("remote four event missing on an output");

  // Defaults must already stand at the first edge after release
  chk_reset_defaults: assert property ($rose(arst_n_i) |-> // see R14
    state.mask2 == otm_pkg::OTM_RST_MASK2[4:0] && state.mask3 == otm_pkg::OTM_RST_MASK3[4:0]
    && state.local_limit == otm_pkg::OTM_RST_LOCAL[6:0] && state.r1t1 == otm_pkg::OTM_RST_R_T1
    && state.r2t1 == otm_pkg::OTM_RST_R_T1 && state.r3 == otm_pkg::OTM_RST_R_CRIT
    && state.r4 == otm_pkg::OTM_RST_R_CRIT && state.r1t2 == otm_pkg::OTM_RST_R_T2
    && state.r2t2 == otm_pkg::OTM_RST_R_T2)
    else $error("register defaults missing after reset release");

  cov_second_fires: cover property ($fell(alarm_out_second_n_o));
  cov_third_fires: cover property ($fell(alarm_out_third_n_o));
  cov_tier2_event: cover property ($rose(ev_shared[otm_pkg::OTM_CH_R1]));
  cov_release: cover property ($rose(alarm_out_second_n_o));

endmodule // otm_bank

// ==== core/otm_pkg.sv ====
// Shared constants and types for the over-temperature mask and limit bank.
// Assumes one 200 MHz core clock and an asynchronous active-low reset.
package otm_pkg;

  // Register command bytes
  localparam logic [7:0] OTM_ADDR_MASK2 = 8'h0D;
  localparam logic [7:0] OTM_ADDR_MASK3 = 8'h0E;
  localparam logic [7:0] OTM_ADDR_LOCAL = 8'h40;
  localparam logic [7:0] OTM_ADDR_R1T1 = 8'h41;
  localparam logic [7:0] OTM_ADDR_R2T1 = 8'h42;
  localparam logic [7:0] OTM_ADDR_R3 = 8'h43;
  localparam logic [7:0] OTM_ADDR_R4 = 8'h44;
  localparam logic [7:0] OTM_ADDR_R1T2 = 8'h49;
  localparam logic [7:0] OTM_ADDR_R2T2 = 8'h4A;

  // Power-on defaults
  localparam logic [7:0] OTM_RST_MASK2 = 8'h00;
  localparam logic [7:0] OTM_RST_MASK3 = 8'h07;
  localparam logic [7:0] OTM_RST_LOCAL = 8'h55;
  localparam logic [7:0] OTM_RST_R_T1 = 8'h6E;
  localparam logic [7:0] OTM_RST_R_CRIT = 8'h55;
  localparam logic [7:0] OTM_RST_R_T2 = 8'h55;
  localparam logic [7:0] OTM_RDATA_IDLE = 8'h00;

  // Field widths
  localparam int unsigned OTM_MASK_W = 5;
  localparam int unsigned OTM_LOCAL_W = 7;
  localparam int unsigned OTM_DATA_W = 8;
  localparam int unsigned OTM_HYST_W = 6;
  localparam logic [5:0] OTM_HYST_MAX = 6'h20;

  // Channel bit positions inside a mask
  localparam int unsigned OTM_CH_LOCAL = 0;
  localparam int unsigned OTM_CH_R1 = 1;
  localparam int unsigned OTM_CH_R2 = 2;
  localparam int unsigned OTM_CH_R3 = 3;
  localparam int unsigned OTM_CH_R4 = 4;

  // Comparator slots
  localparam int unsigned OTM_CMP_LOCAL = 0;
  localparam int unsigned OTM_CMP_R1T1 = 1;
  localparam int unsigned OTM_CMP_R2T1 = 2;
  localparam int unsigned OTM_CMP_R3 = 3;
  localparam int unsigned OTM_CMP_R4 = 4;
  localparam int unsigned OTM_CMP_R1T2 = 5;
  localparam int unsigned OTM_CMP_R2T2 = 6;
  localparam int unsigned OTM_NCMP = 7;

  typedef struct packed {
    logic [4:0] mask2;
    logic [4:0] mask3;
    logic [6:0] local_limit;
    logic [7:0] r1t1;
    logic [7:0] r2t1;
    logic [7:0] r3;
    logic [7:0] r4;
    logic [7:0] r1t2;
    logic [7:0] r2t2;
    logic [7:0] rdata;
  } otm_bank_state_type;

  typedef struct packed {
    logic err;
  } otm_cmp_state_type;

  // Mask readback with reserved upper bits forced low
  function automatic logic [7:0] otm_pad_mask(input logic [4:0] m);
    otm_pad_mask = {3'h0, m};
  endfunction

endpackage

// ==== core/otm_chan_cmp.sv ====
// One limit comparator with shared hysteresis for a temperature channel.
// Assumes readings and limits are whole degrees, synchronous to clk_sys_i.
module otm_chan_cmp (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] reading_i,
  input wire logic [7:0] limit_i,
  input wire logic [5:0] hyst_i,
  output logic err_o
);

  otm_pkg::otm_cmp_state_type state;
  otm_pkg::otm_cmp_state_type next_state;
  logic [8:0] reading_plus_hyst;

  // Adding hysteresis to the reading avoids an underflow of limit minus hysteresis
  assign reading_plus_hyst = {1'b0, reading_i} + {3'h0, hyst_i};

  // Set at or above the limit, clear only below limit minus hysteresis
  always_comb begin
    next_state = state;
    if (reading_i >= limit_i) begin
      next_state.err = 1'b1; // see R11
    end else if (reading_plus_hyst < {1'b0, limit_i}) begin
      next_state.err = 1'b0; // see R11, see R12
    end
  end

  // Flag starts clear so no alarm fires before the first compare
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= '0; // see R14
    end else begin
      state <= next_state;
    end
  end

  assign err_o = state.err;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  chk_err_set_at_limit: assert property (reading_i >= limit_i |=> err_o) // see R11
    else $error("error flag not set at or above limit");
  chk_err_hold_band: assert property (
    err_o && (reading_plus_hyst >= {1'b0, limit_i}) |=> err_o) // see R12
    else $error("error flag dropped inside hysteresis band");
  chk_err_clear_below: assert property (
    reading_plus_hyst < {1'b0, limit_i} |=> !err_o) // see R11
    else $error("error flag not cleared below limit minus hysteresis");

endmodule // otm_chan_cmp

// ==== testbench/otm_host.sv ====
// Host model for the command-byte register port of the limit bank.
// Assumes requests are taken on the rising edge with one-cycle strobes.
module otm_host (
  input wire logic clk_sys_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port from time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end

  // One write; strobe spans exactly one taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
  endtask

  // Write, then read the same byte at the very next edge; data taken where it stands
  task automatic wrrd(input logic [7:0] a, input logic [7:0] dw, output logic [7:0] dr);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= dw;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    @(posedge clk_sys_i);
    dr = reg_rdata_i;
  endtask

  // One read; data is taken an edge later, where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    @(posedge clk_sys_i);
    d = reg_rdata_i;
  endtask
endmodule // otm_host

// ==== testbench/otm_bank_bench.sv ====
// Self-checking bench for the mask and limit bank, with a reference model.
// Assumes the host model drives the register port; readings come from here.
module otm_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic [7:0] rdg [5] = '{default: 8'h00};
  logic [5:0] hyst = 6'h00;
  logic [4:0] err1, err2;
  logic al2_n, al3_n;
  int num_errors = 0;
  int num_checks = 0;
  int unsigned seed = 7519;
  int lim [7];
  int map [7] = '{0, 1, 2, 3, 4, 1, 2};
  int m2, m3, mrd, h;
  bit e [7];
  // Address, power-on value, value read after writing all ones
  logic [7:0] adr [10] = '{8'h0D, 8'h0E, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h49, 8'h4A, 8'h50};
  logic [7:0] por [10] = '{8'h00, 8'h07, 8'h55, 8'h6E, 8'h6E, 8'h55, 8'h55, 8'h55, 8'h55, 8'h00};
  logic [7:0] one [10] = '{8'h1F, 8'h1F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

  always #2.5 clk_sys_i = ~clk_sys_i;

  otm_host host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));

  otm_bank dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .reading_local_i(rdg[0]), .reading_remote1_i(rdg[1]), .reading_remote2_i(rdg[2]),
    .reading_remote3_i(rdg[3]), .reading_remote4_i(rdg[4]), .hyst_i(hyst),
    .error_first_o(err1), .error_shared_o(err2), .alarm_out_second_n_o(al2_n),
    .alarm_out_third_n_o(al3_n));

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Readback view: reserved bits and unmapped places give zero
  function automatic int rmodel(input logic [7:0] a);
    case (a)
      8'h0D: return m2;
      8'h0E: return m3;
      8'h40, 8'h41, 8'h42, 8'h43, 8'h44: return lim[a - 8'h40];
      8'h49, 8'h4A: return lim[a - 8'h44];
      default: return 0;
    endcase
  endfunction

  task automatic wmodel(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h0D: m2 = d & 8'h1F;
      8'h0E: m3 = d & 8'h1F;
      8'h40: lim[0] = d & 8'h7F;
      8'h41, 8'h42, 8'h43, 8'h44: lim[a - 8'h40] = d;
      8'h49, 8'h4A: lim[a - 8'h44] = d;
      default: ;
    endcase
  endtask

  // Model: flags use limits held before this edge, as the flops do
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lim = '{8'h55, 8'h6E, 8'h6E, 8'h55, 8'h55, 8'h55, 8'h55};
      m2 = 0;
      m3 = 7;
      mrd = 0;
      e = '{default: 0};
    end else begin
      h = (hyst > 32) ? 32 : hyst;
      for (int i = 0; i < 7; i++) begin
        if (rdg[map[i]] >= lim[i]) e[i] = 1;
        else if (rdg[map[i]] + h < lim[i]) e[i] = 0;
      end
      if (reg_rd) mrd = rmodel(reg_addr);
      if (reg_wr) wmodel(reg_addr, reg_wdata);
    end
  end

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  // Settled mid-cycle: every output against the model
  always @(negedge clk_sys_i) begin
    logic [4:0] f, s;
    f = {e[4], e[3], e[2], e[1], e[0]};
    s = {e[4], e[3], e[6], e[5], e[0]};
    chk("error_first", 8'(f), 8'(err1));
    chk("error_shared", 8'(s), 8'(err2));
    chk("alarm_second_n", 8'(~|(s & ~m2[4:0])), 8'(al2_n));
    chk("alarm_third_n", 8'(~|(s & ~m3[4:0])), 8'(al3_n));
    chk("rdata", mrd[7:0], reg_rdata);
  end

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Whole sequence needs roughly 2000 cycles
  initial begin
    repeat (6000) @(posedge clk_sys_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] d, a;
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    // Power-on values, then all ones, including an unmapped place
    for (int i = 0; i < 10; i++) begin
      host.rd(adr[i], d);
      chk("reset_value", por[i], d);
      host.wrrd(adr[i], 8'hFF, d);
      chk("ones_readback", one[i], d);
    end
    // Masks open, every limit at 0x50, then sweep readings up and down
    for (int i = 0; i < 9; i++) host.wr(adr[i], (i < 2) ? 8'h00 : 8'h50);
    for (int j = 0; j < 2; j++) begin
      hyst <= j ? 6'h28 : 6'h05;
      for (int t = 0; t < 96; t++) begin
        @(posedge clk_sys_i);
        foreach (rdg[c]) rdg[c] <= 8'((t < 32) ? 8'h40 + t : 8'h7F - t);
      end
    end
    // Random traffic; the monitor compares every cycle
    repeat (300) begin
      a = adr[xs() % 10];
      host.wrrd(a, 8'(xs()), d);
      chk("random_readback", 8'(rmodel(a)), d);
      hyst <= 6'(xs() % 36);
      foreach (rdg[c]) rdg[c] <= 8'(xs());
      repeat (2) @(posedge clk_sys_i);
    end
    print_verdict();
  end
endmodule // otm_bank_bench
